//--- shared/stcp_pkg.sv
// Constants and types shared by the standard timer design files.
// What this block does
// - Counter high byte reads live, read-only.
// - Compare-A value is two read/write bytes.
// - Compare-P byte matches counter upper byte.
// - Compare-P period is value times 256.
// - Clear-select low: clear on P, both flags.
// - Clear-select high: clear on A only.
// - Compare-A zero with clear on A: overflow, no A flag.
// - Mode code 00 selects compare-match output.
// - Only compare-A matches move the pin.
// - Pin action sets, clears or toggles pin.
// - Enable rise loads pin initial level.
// - Mode 11 counts alike, pin unused.
// - PWM ignores clear-select; one sets period.
// - PWM raises both flags on matches.
// - PWM active level, force, invert controls.
// - Action codes: none, low, high, toggle.
// - Enable rise zeroes counter; fall holds.
// - Swap bit exchanges period and duty roles.
package stcp_pkg;
    // Datapath widths.
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFF_CTRL0 = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CTRL1 = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CNT_LO = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CNT_HI = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_CMPA_LO = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_CMPA_HI = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_CMPP = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h1C;
    // Field positions.
    localparam int C0_PAUSE = 7;
    localparam int C0_EN = 3;
    localparam int C1_MODE_HI = 7;
    localparam int C1_MODE_LO = 6;
    localparam int C1_ACT_HI = 5;
    localparam int C1_ACT_LO = 4;
    localparam int C1_INIT = 3;
    localparam int C1_INV = 2;
    localparam int C1_SWAP = 1;
    localparam int C1_CLRSEL = 0;
    localparam int FLG_A = 0;
    localparam int FLG_P = 1;
    // Reset values and fixed patterns.
    localparam logic [BYTE_W-1:0] CTRL0_MASK = 8'h88;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [DATA_W-BYTE_W-1:0] RD_PAD = 24'h000000;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h00000000;
    // Pin action codes: compare meaning, then PWM meaning.
    localparam logic [1:0] ACT_NONE = 2'h0;   // Hold, or force inactive.
    localparam logic [1:0] ACT_LOW = 2'h1;    // Drive low, or force active.
    localparam logic [1:0] ACT_HIGH = 2'h2;   // Drive high, or waveform.
    localparam logic [1:0] ACT_TOGGLE = 2'h3; // Toggle, or force inactive.
    // Operating modes.
    typedef enum logic [1:0] {
        MODE_CMP = 2'h0,
        MODE_CAP = 2'h1,
        MODE_PWM = 2'h2,
        MODE_TMR = 2'h3
    } stcp_mode_t;
    // Waveform phase inside one PWM period.
    typedef enum logic {
        PH_INACTIVE = 1'h0,
        PH_ACTIVE = 1'h1
    } stcp_phase_t;
endpackage : stcp_pkg

//--- shared/stcp_if.sv
// Interface joining the register block to the counter and pin logic.
`timescale 1ns/1ps
interface stcp_if;
    import stcp_pkg::*;
    logic ce;                  // State holds while low.
    logic start;               // One-cycle pulse on enable rise.
    logic running;             // Enabled and not paused.
    stcp_mode_t mode;          // Operating mode.
    logic [1:0] pin_act;       // Pin action field.
    logic init_lvl;            // Initial or active level.
    logic invert;              // Output inversion.
    logic swap;                // Duty and period exchange.
    logic clr_sel;             // Clear source in compare modes.
    logic [CNT_W-1:0] compare_a_value;    // Compare-A value.
    logic [BYTE_W-1:0] compare_p_value;   // Compare-P value.
    logic [CNT_W-1:0] cnt;     // Live counter.
    logic a_evt;               // Compare-A flag event.
    logic p_evt;               // Compare-P flag event.
    logic period_hit;          // PWM period clear.
    logic duty_hit;            // PWM duty match.
    logic pin;                 // Registered pin level.
    logic pin_oe;              // Registered pin enable.
    modport counter (input ce, start, running, mode, swap, clr_sel, compare_a_value, compare_p_value,
                     output cnt, a_evt, p_evt, period_hit, duty_hit);
    modport pin_side (input ce, start, mode, pin_act, init_lvl, invert, a_evt,
                      period_hit, duty_hit, output pin, pin_oe);
endinterface : stcp_if

//--- hdl/stcp_counter.sv
// Sixteen-bit counter with the two comparators and their events.
`timescale 1ns/1ps
module stcp_counter (
    input wire logic clk_in,
    input wire logic rst_in,
    stcp_if.counter tif
);
    import stcp_pkg::*;
    logic [CNT_W-1:0] cnt_r;   // Counter state.
    logic [CNT_W-1:0] cnt_nxt; // Next counter value.
    logic [CNT_W-1:0] cnt_inc; // Counter plus one, wrapping.
    logic a_wrap;              // Next value equals compare-A.
    logic a_match;             // Compare-A match with nonzero value.
    logic p_match;             // Next value hits compare-P boundary.
    logic clr;                 // Clear instead of incrementing.

    // Matches look at the next value so that a match clears on time.
    always_comb begin
        cnt_inc = cnt_r + CNT_ONE;
        a_wrap = (cnt_inc == tif.compare_a_value);
        a_match = a_wrap && (tif.compare_a_value != CNT_RST);
        p_match = (cnt_inc == {tif.compare_p_value, BYTE_RST});
        clr = 1'b0;
        tif.a_evt = 1'b0;
        tif.p_evt = 1'b0;
        tif.period_hit = 1'b0;
        tif.duty_hit = 1'b0;
        case (tif.mode)
            MODE_CMP, MODE_TMR: begin
                tif.a_evt = a_match;
                if (tif.clr_sel) begin
                    clr = a_match;
                end else begin
                    clr = p_match;
                    tif.p_evt = p_match;
                end
            end
            MODE_PWM: begin
                tif.a_evt = a_match;
                tif.p_evt = p_match;
                if (tif.swap) begin
                    clr = a_wrap;
                    tif.period_hit = a_wrap;
                    tif.duty_hit = p_match;
                end else begin
                    clr = p_match;
                    tif.period_hit = p_match;
                    tif.duty_hit = a_wrap;
                end
            end
            default: begin
                clr = 1'b0;
            end
        endcase
        // Events only count while the counter really advances.
        if (!tif.running || tif.start) begin
            tif.a_evt = 1'b0;
            tif.p_evt = 1'b0;
            tif.period_hit = 1'b0;
            tif.duty_hit = 1'b0;
        end
        cnt_nxt = cnt_r;
        if (tif.start) begin
            cnt_nxt = CNT_RST;
        end else if (tif.running) begin
            cnt_nxt = clr ? CNT_RST : cnt_inc;
        end
    end

    // Counter register, frozen by the clock enable.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= CNT_RST;
        end else if (tif.ce) begin
            cnt_r <= cnt_nxt;
        end
    end

    assign tif.cnt = cnt_r;
endmodule : stcp_counter

//--- hdl/stcp_pin.sv
// Output pin logic for compare-match and PWM modes.
`timescale 1ns/1ps
module stcp_pin (
    input wire logic clk_in,
    input wire logic rst_in,
    stcp_if.pin_side tif
);
    import stcp_pkg::*;
    logic lvl_r;              // Compare-mode pin level.
    logic lvl_nxt;
    stcp_phase_t phase_r;     // PWM phase.
    stcp_phase_t phase_nxt;
    logic pin_r;              // Final pin level.
    logic pin_nxt;
    logic oe_r;               // Pin drive enable.
    logic oe_nxt;
    logic wave;               // PWM level before inversion.

    // Next level, phase and final pin value.
    always_comb begin
        lvl_nxt = lvl_r;
        phase_nxt = phase_r;
        wave = ~tif.init_lvl;
        if (tif.start) begin
            lvl_nxt = tif.init_lvl;
            phase_nxt = PH_ACTIVE;
        end else begin
            if (tif.mode == MODE_CMP && tif.a_evt) begin
                case (tif.pin_act)
                    ACT_LOW: lvl_nxt = 1'b0;
                    ACT_HIGH: lvl_nxt = 1'b1;
                    ACT_TOGGLE: lvl_nxt = ~lvl_r;
                    default: lvl_nxt = lvl_r;
                endcase
            end
            // A period clear outranks a duty match in the same cycle.
            if (tif.period_hit) begin
                phase_nxt = PH_ACTIVE;
            end else if (tif.duty_hit) begin
                phase_nxt = PH_INACTIVE;
            end
        end
        case (tif.pin_act)
            ACT_LOW: wave = tif.init_lvl;
            ACT_HIGH: wave = (phase_nxt == PH_ACTIVE) ? tif.init_lvl : ~tif.init_lvl;
            default: wave = ~tif.init_lvl;
        endcase
        case (tif.mode)
            MODE_CMP: begin
                oe_nxt = 1'b1;
                pin_nxt = lvl_nxt ^ tif.invert;
            end
            MODE_PWM: begin
                oe_nxt = 1'b1;
                pin_nxt = wave ^ tif.invert;
            end
            default: begin
                oe_nxt = 1'b0;
                pin_nxt = 1'b0;
            end
        endcase
    end

    // Pin registers, frozen by the clock enable.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lvl_r <= 1'b0;
            phase_r <= PH_INACTIVE;
            pin_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (tif.ce) begin
            lvl_r <= lvl_nxt;
            phase_r <= phase_nxt;
            pin_r <= pin_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign tif.pin = pin_r;
    assign tif.pin_oe = oe_r;
endmodule : stcp_pin

//--- hdl/stcp_top.sv
// Standard timer top: APB registers, counter and output pin.
`timescale 1ns/1ps
module stcp_top (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [stcp_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [stcp_pkg::DATA_W-1:0] pwdata_in,
    output logic [stcp_pkg::DATA_W-1:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic timer_pin_out,
    output logic timer_pin_oe_out
);
    import stcp_pkg::*;

    //------------------------------------------------------------
    // Register state
    //------------------------------------------------------------

    // Control word 0: pause and enable.
    logic [BYTE_W-1:0] ctrl0_r;
    logic [BYTE_W-1:0] ctrl0_nxt;

    // Control word 1: mode and pin settings.
    logic [BYTE_W-1:0] ctrl1_r;
    logic [BYTE_W-1:0] ctrl1_nxt;

    // Compare-A bytes.
    logic [BYTE_W-1:0] compare_a_value_lo_r;
    logic [BYTE_W-1:0] compare_a_value_lo_nxt;
    logic [BYTE_W-1:0] compare_a_value_hi_r;
    logic [BYTE_W-1:0] compare_a_value_hi_nxt;

    // Compare-P byte.
    logic [BYTE_W-1:0] compare_p_value_r;
    logic [BYTE_W-1:0] compare_p_value_nxt;

    // Sticky match flags.
    logic flag_a_r;
    logic flag_a_nxt;
    logic flag_p_r;
    logic flag_p_nxt;

    // Enable as seen one cycle before.
    logic en_prev_r;
    logic en_prev_nxt;

    // Read data and error captured in setup.
    logic [DATA_W-1:0] prdata_r;
    logic [DATA_W-1:0] prdata_nxt;
    logic slverr_r;
    logic slverr_nxt;

    // High once read data and error are captured for the transfer in flight.
    logic held_r;
    logic held_nxt;

    //------------------------------------------------------------
    // Bus decode
    //------------------------------------------------------------

    logic setup;                // Setup phase of a transfer.
    logic access;               // Access phase of a transfer.
    logic wr_acc;               // Write taking effect.
    logic hit;                  // Address is mapped.
    logic [DATA_W-1:0] rd_word; // Read value for the address.
    logic clr_a;                // Software clears flag A.
    logic clr_p;                // Software clears flag P.

    // Shared block signals.
    stcp_if u_if ();

    assign setup = psel_in && !penable_in;
    assign access = psel_in && penable_in;
    assign wr_acc = access && pwrite_in && held_r;

    //------------------------------------------------------------
    // Register next values
    //------------------------------------------------------------

    // Address decode, writes, flag updates and read capture.
    always_comb begin
        rd_word = RD_ZERO;
        hit = 1'b1;
        case (paddr_in)
            OFF_CTRL0: rd_word = {RD_PAD, ctrl0_r};
            OFF_CTRL1: rd_word = {RD_PAD, ctrl1_r};
            OFF_CNT_LO: rd_word = {RD_PAD, u_if.cnt[BYTE_W-1:0]};
            OFF_CNT_HI: rd_word = {RD_PAD, u_if.cnt[CNT_W-1:BYTE_W]};
            OFF_CMPA_LO: rd_word = {RD_PAD, compare_a_value_lo_r};
            OFF_CMPA_HI: rd_word = {RD_PAD, compare_a_value_hi_r};
            OFF_CMPP: rd_word = {RD_PAD, compare_p_value_r};
            OFF_FLAGS: rd_word = {RD_PAD, BYTE_RST[BYTE_W-1:2], flag_p_r, flag_a_r};
            default: hit = 1'b0;
        endcase

        // Captured once per transfer, even if the setup edge was frozen.
        prdata_nxt = (psel_in && !held_r) ? rd_word : prdata_r;
        slverr_nxt = (psel_in && !held_r) ? !hit : slverr_r;
        // Cleared at the completing access edge, so back-to-back setups capture again.
        held_nxt = psel_in && !(penable_in && held_r);

        // Writes land only in the access phase.
        ctrl0_nxt = ctrl0_r;
        ctrl1_nxt = ctrl1_r;
        compare_a_value_lo_nxt = compare_a_value_lo_r;
        compare_a_value_hi_nxt = compare_a_value_hi_r;
        compare_p_value_nxt = compare_p_value_r;
        clr_a = 1'b0;
        clr_p = 1'b0;
        if (wr_acc) begin
            case (paddr_in)
                OFF_CTRL0: ctrl0_nxt = pwdata_in[BYTE_W-1:0] & CTRL0_MASK;
                OFF_CTRL1: ctrl1_nxt = pwdata_in[BYTE_W-1:0];
                OFF_CMPA_LO: compare_a_value_lo_nxt = pwdata_in[BYTE_W-1:0];
                OFF_CMPA_HI: compare_a_value_hi_nxt = pwdata_in[BYTE_W-1:0];
                OFF_CMPP: compare_p_value_nxt = pwdata_in[BYTE_W-1:0];
                OFF_FLAGS: begin
                    clr_a = pwdata_in[FLG_A];
                    clr_p = pwdata_in[FLG_P];
                end
                default: begin
                    clr_a = 1'b0;
                end
            endcase
        end

        // A new match wins over a clear in the same cycle.
        flag_a_nxt = u_if.a_evt || (flag_a_r && !clr_a);
        flag_p_nxt = u_if.p_evt || (flag_p_r && !clr_p);

        // Remember the enable to find its rising edge.
        en_prev_nxt = ctrl0_r[C0_EN];
    end

    //------------------------------------------------------------
    // Register flops
    //------------------------------------------------------------

    // All register state, frozen by the clock enable.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl0_r <= BYTE_RST;
            ctrl1_r <= BYTE_RST;
            compare_a_value_lo_r <= BYTE_RST;
            compare_a_value_hi_r <= BYTE_RST;
            compare_p_value_r <= BYTE_RST;
            flag_a_r <= 1'b0;
            flag_p_r <= 1'b0;
            en_prev_r <= 1'b0;
            prdata_r <= RD_ZERO;
            slverr_r <= 1'b0;
            held_r <= 1'b0;
        end else if (ce_in) begin
            ctrl0_r <= ctrl0_nxt;
            ctrl1_r <= ctrl1_nxt;
            compare_a_value_lo_r <= compare_a_value_lo_nxt;
            compare_a_value_hi_r <= compare_a_value_hi_nxt;
            compare_p_value_r <= compare_p_value_nxt;
            flag_a_r <= flag_a_nxt;
            flag_p_r <= flag_p_nxt;
            en_prev_r <= en_prev_nxt;
            prdata_r <= prdata_nxt;
            slverr_r <= slverr_nxt;
            held_r <= held_nxt;
        end
    end

    //------------------------------------------------------------
    // Block wiring
    //------------------------------------------------------------

    // Settings handed to the counter and the pin logic.
    assign u_if.ce = ce_in;
    assign u_if.start = ctrl0_r[C0_EN] && !en_prev_r;
    assign u_if.running = ctrl0_r[C0_EN] && !ctrl0_r[C0_PAUSE];
    assign u_if.mode = stcp_mode_t'(ctrl1_r[C1_MODE_HI:C1_MODE_LO]);
    assign u_if.pin_act = ctrl1_r[C1_ACT_HI:C1_ACT_LO];
    assign u_if.init_lvl = ctrl1_r[C1_INIT];
    assign u_if.invert = ctrl1_r[C1_INV];
    assign u_if.swap = ctrl1_r[C1_SWAP];
    assign u_if.clr_sel = ctrl1_r[C1_CLRSEL];
    assign u_if.compare_a_value = {compare_a_value_hi_r, compare_a_value_lo_r};
    assign u_if.compare_p_value = compare_p_value_r;

    // Counter and comparators.
    stcp_counter u_counter (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .tif(u_if)
    );

    // Output pin.
    stcp_pin u_pin (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .tif(u_if)
    );

    // Bus answers; the slave stalls while frozen or until the read data is captured.
    assign pready_out = ce_in && held_r;
    assign prdata_out = prdata_r;
    assign pslverr_out = slverr_r && access;
    assign timer_pin_out = u_if.pin;
    assign timer_pin_oe_out = u_if.pin_oe;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------

    // A high byte read returns the counter at setup.
    a_high_byte_read: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ce_in && setup && paddr_in == OFF_CNT_HI
        |=> prdata_r == {RD_PAD, $past(u_if.cnt[CNT_W-1:BYTE_W])})
        else $error("High byte read does not match the counter.");

    // The compare-A high byte takes the written data.
    a_cmpa_high_write: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ce_in && wr_acc && paddr_in == OFF_CMPA_HI
        |=> u_if.compare_a_value[CNT_W-1:BYTE_W] == $past(pwdata_in[BYTE_W-1:0]))
        else $error("Compare-A high byte write lost.");

    // A compare-P match clears the counter and sets flag P.
    a_p_match_clear: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ce_in && u_if.running && !u_if.start && !u_if.clr_sel
        && (u_if.mode == MODE_CMP || u_if.mode == MODE_TMR)
        && u_if.cnt + CNT_ONE == {compare_p_value_r, BYTE_RST}
        |=> u_if.cnt == CNT_RST && flag_p_r)
        else $error("Compare-P match did not clear and flag.");

    // With clear-select high no P flag appears.
    a_no_p_flag: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ce_in && u_if.clr_sel && !flag_p_r
        && (u_if.mode == MODE_CMP || u_if.mode == MODE_TMR)
        |=> !flag_p_r)
        else $error("Flag P set while clearing on compare-A.");

    // A zero compare-A value never raises flag A.
    a_zero_a_silent: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ce_in && u_if.compare_a_value == CNT_RST && !flag_a_r
        |=> !flag_a_r)
        else $error("Flag A set with compare-A zero.");

    // An enable rise zeroes the counter.
    a_start_zero: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ce_in && u_if.start |=> u_if.cnt == CNT_RST)
        else $error("Counter not zero after enable rise.");

    // A stopped or paused counter keeps its value.
    a_stop_holds: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ce_in && !u_if.running && !u_if.start |=> $stable(u_if.cnt))
        else $error("Counter moved while stopped.");

    // An enable rise in compare mode loads the initial level.
    a_pin_initial: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ce_in && u_if.start && u_if.mode == MODE_CMP && !wr_acc
        |=> timer_pin_out == (u_if.init_lvl ^ u_if.invert))
        else $error("Pin not at initial level after enable rise.");

    // A toggle action flips the pin on a compare-A event.
    a_pin_toggle: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ce_in && u_if.mode == MODE_CMP && u_if.pin_act == ACT_TOGGLE
        && u_if.a_evt && !wr_acc && $stable(ctrl1_r)
        |=> timer_pin_out != $past(timer_pin_out))
        else $error("Pin did not toggle on compare-A.");

    // Without a compare-A event the compare pin stays put.
    a_pin_steady: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ce_in && u_if.mode == MODE_CMP && !u_if.a_evt && !u_if.start
        && !wr_acc && timer_pin_oe_out && $stable(ctrl1_r)
        |=> $stable(timer_pin_out))
        else $error("Pin changed without compare-A event.");

    // Flags A and P both follow PWM matches.
    a_pwm_flags: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ce_in && u_if.mode == MODE_PWM && (u_if.a_evt || u_if.p_evt)
        |=> (flag_a_r || !$past(u_if.a_evt)) && (flag_p_r || !$past(u_if.p_evt)))
        else $error("PWM match flags missing.");

    // A PWM period clear restarts the active phase.
    a_pwm_period: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ce_in && u_if.mode == MODE_PWM && u_if.pin_act == ACT_HIGH
        && u_if.period_hit && !wr_acc
        |=> u_if.cnt == CNT_RST
        && timer_pin_out == (u_if.init_lvl ^ u_if.invert))
        else $error("PWM period did not restart active level.");

    // Timer mode leaves the pin undriven.
    a_timer_no_pin: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ce_in && u_if.mode == MODE_TMR && !wr_acc
        |=> !timer_pin_oe_out)
        else $error("Pin driven in timer mode.");

endmodule : stcp_top

//--- verif/tb_top.sv
// Self-checking testbench for the standard timer top.
`timescale 1ns/1ps
module tb_top;
    import stcp_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce = 1'b1; // Clock enable, dropped once to freeze the counter.
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [ADDR_W-1:0] pa = 8'h00;
    logic [DATA_W-1:0] pw = 32'h00000000;
    logic [DATA_W-1:0] rdata;
    logic rdy, err, pin, oe;
    logic [32:0] exp_q[$]; // Expected {pslverr, read data} per transfer.
    int failures = 0;
    int num_checks = 0;
    stcp_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pw), .prdata_out(rdata), .pready_out(rdy),
        .pslverr_out(err), .timer_pin_out(pin), .timer_pin_oe_out(oe));
    // 50 MHz clock.
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    task automatic chk(input logic [32:0] e, input logic [32:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    // One APB transfer; the monitor compares it at the completing edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        int n = 0;
        exp_q.push_back(e);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pw <= d;
        @(posedge clk_in);
        pen <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        if (rdy !== 1'b1) begin
            failures++;
            final_report();
        end
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk_in);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d}, 33'h000000000);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h00000000, {1'b0, 24'h000000, e});
    endtask : rd
    // Stop, program the control byte, then raise the enable again.
    task automatic start(input logic [7:0] c1);
        wr(OFF_CTRL0, 8'h00);
        wr(OFF_CTRL1, c1);
        wr(OFF_CTRL0, 8'h08);
    endtask : start
    // Counts high pin cycles over a window that spans whole periods, so phase does not matter.
    task automatic pin_count(input int w, input int n, input int e);
        logic [32:0] c = 33'h000000000;
        repeat (w) @(posedge clk_in);
        repeat (n) begin
            @(posedge clk_in);
            c = c + pin;
        end
        chk(33'(e), c);
    endtask : pin_count
    // Monitor: takes the oldest note at every completed transfer.
    always @(posedge clk_in) begin
        if (psel && pen && rdy === 1'b1) begin
            chk(exp_q[0], {err, pwr ? exp_q[0][31:0] : rdata});
            void'(exp_q.pop_front());
        end
    end
    initial begin
        int i;
        logic [7:0] v;
        int cmp_exp[4] = '{0, 0, 768, 384};
        i = $urandom(77);
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        for (i = 0; i < 8; i++) begin
            rd(8'(i * 4), 8'h00);
        end
        for (i = 0; i < 3; i++) begin
            v = 8'($urandom);
            wr(8'(OFF_CMPA_LO + i * 4), v);
            rd(8'(OFF_CMPA_LO + i * 4), v);
        end
        wr(OFF_CNT_HI, 8'hFF);
        rd(OFF_CNT_HI, 8'h00);
        apb(1'b0, 8'h20, 32'h00000000, {1'b1, 32'h00000000});
        // Compare mode, clear on A with compare-P below compare-A.
        wr(OFF_CMPA_LO, 8'h80);
        wr(OFF_CMPA_HI, 8'h01);
        wr(OFF_CMPP, 8'h01);
        for (i = 0; i < 4; i++) begin
            start({2'b00, 2'(i), i == 1, 3'b001});
            pin_count(0, 4, (i == 1) ? 4 : 0);
            pin_count(400, 768, cmp_exp[i]);
        end
        wr(OFF_CTRL0, 8'h00);
        rd(OFF_FLAGS, 8'h01);
        wr(OFF_FLAGS, 8'h03);
        rd(OFF_FLAGS, 8'h00);
        // Timer mode, clear on compare-P every 256 clocks.
        wr(OFF_CMPA_HI, 8'h00);
        start(8'hC0);
        // Twenty counted clocks, then a frozen stretch that must add nothing.
        repeat (20) @(posedge clk_in);
        ce <= 1'b0;
        repeat (40) @(posedge clk_in);
        ce <= 1'b1;
        rd(OFF_CNT_LO, 8'h14);
        pin_count(300, 1, 0);
        chk(33'h000000000, {32'h00000000, oe});
        rd(OFF_CNT_HI, 8'h00);
        wr(OFF_CTRL0, 8'h00);
        rd(OFF_FLAGS, 8'h03);
        wr(OFF_FLAGS, 8'h03);
        // Compare-A zero: the counter runs on, but flag A stays low.
        wr(OFF_CMPA_LO, 8'h00);
        start(8'hC0);
        pin_count(300, 1, 0);
        wr(OFF_CTRL0, 8'h00);
        rd(OFF_FLAGS, 8'h02);
        wr(OFF_FLAGS, 8'h03);
        // PWM: period 256, duty 64; clear-select, invert, then swap with compare-A 128 as period.
        wr(OFF_CMPA_LO, 8'h40);
        start(8'hA8);
        pin_count(300, 512, 128);
        rd(OFF_FLAGS, 8'h03);
        start(8'hA9);
        pin_count(300, 512, 128);
        start(8'hAC);
        pin_count(300, 512, 384);
        wr(OFF_CMPA_LO, 8'h80);
        start(8'hAA);
        pin_count(300, 512, 512);
        chk(33'h000000001, {32'h00000000, oe});
        final_report();
    end
endmodule : tb_top
